/* bench/rsc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_bench import rsc_pkg::*;;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [AW-1:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [DW-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [3:0] be = 4'hF;
    logic [DW-1:0] avs_readdata, q;
    logic avs_waitrequest, cmd_valid, listen_addressed, poll_req, talk_req;
    logic [3:0] cmd_op;
    logic [VAL_W-1:0] cmd_data, talk_data, level_out, v, lv;
    logic external_step_input = 1'h0;
    logic limiter_active = 1'h0;
    logic srq, poll_valid, talk_valid, output_on, irq;
    logic [7:0] poll_byte;
    logic [RANGE_W-1:0] range_out, r;
    bit m_en, m_lim, m_syn, m_set, m_stp;
    int m_lvl, bad_count, compares;
    always #4 clk = ~clk;
    rsc_ctrl #(.SCAN_PERIOD(24'h000004)) u_dut (.clk, .rst_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cmd_valid, .cmd_op, .cmd_data,
        .listen_addressed, .poll_req, .talk_req, .external_step_input,
        .limiter_active, .srq, .poll_byte, .poll_valid, .talk_data,
        .talk_valid, .level_out, .output_on, .range_out, .irq);
    rsc_host u_host (.clk, .poll_valid, .poll_byte, .talk_valid,
        .listen_addressed, .cmd_valid, .cmd_op, .cmd_data, .poll_req,
        .talk_req);
    // ======================================================
    // checking helpers
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic poll_chk();
        logic [7:0] b, e;
        bit ok, mine;
        e = 8'h00;
        e[SB_LIMIT] = m_lim;
        e[SB_SYNTAX] = m_syn;
        e[SB_SETTLED] = m_set;
        e[SB_STEP] = m_stp;
        e[SB_RQS] = m_en & (m_lim | m_syn | m_set | m_stp);
        u_host.ask(1'h0, b, ok, mine);
        if (!ok) begin
            bad_count++;
            give_verdict();
        end
        chk({24'h0, b}, {24'h0, e}, "status byte");
        m_lim = 0;
        m_set = 0;
        m_stp = 0;
    endtask
    task automatic bus(input bit w, input logic [AW-1:0] a,
                       input logic [DW-1:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (!avs_waitrequest) break;
        end
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (i == 20) begin
            bad_count++;
            give_verdict();
        end
    endtask
    // async pins are held long enough to pass the synchronisers
    task automatic pulse(input bit step);
        @(posedge clk);
        if (step) external_step_input <= 1'h1;
        else limiter_active <= 1'h1;
        repeat (6) @(posedge clk);
        external_step_input <= 1'h0;
        limiter_active <= 1'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic cmds(input logic [3:0] op, input logic [VAL_W-1:0] d);
        u_host.send(op, d);
        u_host.idle(1);
        @(negedge clk);
    endtask
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
    // ======================================================
    // main sequence
    initial begin
        bit ok, mine;
        logic [7:0] b;
        void'($urandom(52));
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk(srq, 0, "srq after reset");
        bus(0, REG_CTRL, 0);
        chk(q, 0, "ctrl after reset");
        bus(0, 5'h1C, 0);
        chk(q, 0, "unmapped read");
        be = 4'($urandom) & 4'hE;
        bus(1, REG_CTRL, 1);
        bus(0, REG_CTRL, 0);
        chk(q, 0, "lane 0 masked write");
        be = 4'hF;
        bus(1, REG_CTRL, 1);
        bus(0, REG_CTRL, 0);
        chk(q, 1, "request enable by bus");
        $display("reset test done");
        u_host.addr(1);
        u_host.send(CMD_REQ_EN, 0);
        cmds(CMD_BAD, 0);
        m_en = 1;
        m_syn = 1;
        chk(srq, 1, "srq on syntax error");
        poll_chk();
        @(negedge clk);
        chk(srq, 1, "syntax kept after poll");
        v = $urandom & 20'h0FFFF;
        cmds(CMD_SET, v);
        m_syn = 0;
        m_lvl = v;
        chk(srq, 0, "srq after correction");
        poll_chk();
        $display("syntax test done");
        bus(1, REG_IRQ_STAT, 32'hF);
        bus(1, REG_IRQ_MASK, 32'h1 << IRQ_LIMIT);
        pulse(1'h0);
        m_lim = 1;
        @(negedge clk);
        chk(srq, 1, "srq on limiter");
        chk(irq, 1, "irq on limiter");
        u_host.send(CMD_NOP, 0);
        cmds(CMD_REQ_EN, 0);
        chk(srq, 1, "overload kept");
        bus(1, REG_IRQ_MASK, 0);
        @(negedge clk);
        chk(irq, 0, "irq masked");
        bus(1, REG_IRQ_MASK, 32'h1 << IRQ_LIMIT);
        bus(1, REG_IRQ_STAT, 32'h1 << IRQ_LIMIT);
        @(negedge clk);
        chk(irq, 0, "irq cleared");
        poll_chk();
        @(negedge clk);
        chk(srq, 0, "srq after poll");
        $display("limiter test done");
        v = $urandom & 20'h0FFFF;
        cmds(CMD_BUF, v);
        chk(level_out, m_lvl, "buffer only");
        u_host.addr(0);
        cmds(CMD_OPERATE, 0);
        chk(output_on, 0, "operate ignored");
        u_host.addr(1);
        cmds(CMD_OPERATE, 0);
        m_lvl = v;
        m_set = 1;
        chk(level_out, m_lvl, "operate loads buffer");
        poll_chk();
        $display("buffer test done");
        r = $urandom;
        v = $urandom & 20'h0FFFF;
        u_host.send(CMD_STANDBY, 0);
        u_host.send(CMD_RANGE, {17'h0, r});
        @(negedge clk);
        chk(output_on, 0, "standby first");
        u_host.send(CMD_SET, v);
        cmds(CMD_OPERATE, 0);
        m_lvl = v;
        m_set = 1;
        chk({output_on, range_out, level_out}, {1'h1, r, v}, "sequence");
        poll_chk();
        $display("sequence test done");
        cmds(CMD_CONT, 0);
        repeat (40) @(posedge clk);
        pulse(1'h1);
        @(negedge clk);
        lv = level_out;
        chk(lv > m_lvl, 1, "scan stepped");
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(level_out, lv, "scan stopped");
        m_stp = 1;
        chk(srq, 1, "srq on step");
        u_host.ask(1'h1, b, ok, mine);
        chk(ok, 1, "talker answer");
        chk(talk_data, lv, "talker value");
        poll_chk();
        $display("scan test done");
        cmds(CMD_REQ_DIS, 0);
        pulse(1'h0);
        m_en = 0;
        m_lim = 1;
        chk(srq, 0, "requests disabled");
        poll_chk();
        $display("disable test done");
        cmds(CMD_CLEAR, 0);
        chk({output_on, range_out, level_out}, 0, "clear defaults");
        bus(0, REG_CTRL, 0);
        chk(q, 0, "clear disables requests");
        $display("clear test done");
        give_verdict();
    end
endmodule // rsc_ctrl_bench
`default_nettype wire

/* bench/rsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// bus controller model: sends codes, polls, requests talker data
module rsc_host import rsc_pkg::*; (
    input wire logic clk, // system clock
    input wire logic poll_valid, // poll answer pulse
    input wire logic [7:0] poll_byte, // polled status byte
    input wire logic talk_valid, // talker answer pulse
    output logic listen_addressed, // listener select
    output logic cmd_valid, // code strobe
    output logic [3:0] cmd_op, // code
    output logic [VAL_W-1:0] cmd_data, // code value
    output logic poll_req, // poll strobe
    output logic talk_req // talk strobe
);
    initial begin
        listen_addressed = 1'h0;
        cmd_valid = 1'h0;
        cmd_op = 4'h0;
        cmd_data = 20'h5A5A5;
        poll_req = 1'h0;
        talk_req = 1'h0;
    end
    task automatic addr(input bit on);
        @(posedge clk);
        listen_addressed <= on;
    endtask
    task automatic send(input logic [3:0] op, input logic [VAL_W-1:0] d);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_data <= d;
    endtask
    // released value lines toggle so a stale value is never read as good
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            cmd_valid <= 1'h0;
            cmd_data <= ~cmd_data;
        end
    endtask
    task automatic ask(input bit talk, output logic [7:0] b,
                       output bit ok, output bit mine);
        @(posedge clk);
        poll_req <= !talk;
        talk_req <= talk;
        @(posedge clk);
        poll_req <= 1'h0;
        talk_req <= 1'h0;
        ok = 0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            ok = poll_valid | talk_valid;
        end
        b = poll_byte;
        mine = b >= 8'h40;
    endtask
endmodule // rsc_host
`default_nettype wire

/* include/rsc_pkg.sv */
// ==========================================================
// remote request and command control: shared definitions
package rsc_pkg;
    // ======================================================
    // register bus
    localparam int AW = 5;
    localparam int DW = 32;
    localparam logic [AW-1:0] REG_CTRL = 5'h00;
    localparam logic [AW-1:0] REG_STATE = 5'h04;
    localparam logic [AW-1:0] REG_SETVAL = 5'h08;
    localparam logic [AW-1:0] REG_BUFVAL = 5'h0C;
    localparam logic [AW-1:0] REG_IRQ_STAT = 5'h10;
    localparam logic [AW-1:0] REG_IRQ_MASK = 5'h14;
    localparam logic [AW-1:0] REG_SCAN_DIV = 5'h18;
    localparam int CTRL_REQ_EN = 0;
    // ======================================================
    // polled status byte fields
    localparam int SB_LIMIT = 0;
    localparam int SB_SYNTAX = 1;
    localparam int SB_SETTLED = 2;
    localparam int SB_STEP = 5;
    localparam int SB_RQS = 6;
    // state register view: status byte in 7:0, flags above
    localparam int ST_SRQ = 8;
    localparam int ST_OPERATE = 9;
    localparam int ST_SCANNING = 10;
    localparam int ST_BUF_VALID = 11;
    localparam int ST_RANGE = 12;
    // ======================================================
    // interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_LIMIT = 0;
    localparam int IRQ_SYNTAX = 1;
    localparam int IRQ_STEP = 2;
    localparam int IRQ_POLL = 3;
    // ======================================================
    // widths and defaults
    localparam int VAL_W = 20;
    localparam int RANGE_W = 3;
    localparam int TICK_W = 24;
    localparam logic [TICK_W-1:0] SCAN_PERIOD_DEF = 24'h0F4240;
    localparam logic [VAL_W-1:0] UNIT_STEP_DEF = 20'h00001;
    // ======================================================
    // decoded program codes from the bus front end
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_STANDBY = 4'h1,
        CMD_OPERATE = 4'h2,
        CMD_SET = 4'h3,
        CMD_BUF = 4'h4,
        CMD_REQ_EN = 4'h5,
        CMD_REQ_DIS = 4'h6,
        CMD_CONT = 4'h7,
        CMD_RANGE = 4'h8,
        CMD_CLEAR = 4'h9,
        CMD_BAD = 4'hA
    } rsc_cmd_t;
    // ======================================================
    // state of the main block
    typedef struct packed {
        logic step_s1;
        logic step_s2;
        logic step_s3;
        logic lim_s1;
        logic lim_s2;
        logic lim_s3;
        logic req_en;
        logic operate;
        logic scanning;
        logic st_limit;
        logic st_syntax;
        logic st_settled;
        logic st_step;
        logic [VAL_W-1:0] set_val;
        logic [VAL_W-1:0] buf_val;
        logic buf_valid;
        logic [RANGE_W-1:0] range;
        logic [VAL_W-1:0] talk_data;
        logic talk_valid;
        logic [7:0] poll_byte;
        logic poll_valid;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic ack;
        logic [DW-1:0] rdata;
        logic [TICK_W-1:0] scan_div;
    } rsc_state_t;
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } rsc_tick_state_t;
endpackage

/* src/rsc_ctrl.sv */
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl import rsc_pkg::*; #(
    parameter logic [TICK_W-1:0] SCAN_PERIOD = SCAN_PERIOD_DEF,
    parameter logic [VAL_W-1:0] UNIT_STEP = UNIT_STEP_DEF
) (
    input wire logic clk, // system clock, 125 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [AW-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [DW-1:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // write byte lanes
    output logic [DW-1:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall request
    input wire logic cmd_valid, // decoded code strobe
    input wire logic [3:0] cmd_op, // decoded code
    input wire logic [VAL_W-1:0] cmd_data, // value or range
    input wire logic listen_addressed, // addressed as listener
    input wire logic poll_req, // serial poll strobe
    input wire logic talk_req, // talker data strobe
    input wire logic external_step_input, // asynchronous pin
    input wire logic limiter_active, // asynchronous pin
    output logic srq, // service request line
    output logic [7:0] poll_byte, // status byte of last poll
    output logic poll_valid, // poll answer pulse
    output logic [VAL_W-1:0] talk_data, // panel set value
    output logic talk_valid, // talker answer pulse
    output logic [VAL_W-1:0] level_out, // applied set value
    output logic output_on, // operate state
    output logic [RANGE_W-1:0] range_out, // selected range
    output logic irq // level interrupt
);
    // ======================================================
    // helpers
    function automatic logic [7:0] sb_pack(input rsc_state_t s,
                                           input logic rq);
        sb_pack = 8'h00;
        sb_pack[SB_LIMIT] = s.st_limit;
        sb_pack[SB_SYNTAX] = s.st_syntax;
        sb_pack[SB_SETTLED] = s.st_settled;
        sb_pack[SB_STEP] = s.st_step;
        sb_pack[SB_RQS] = rq;
    endfunction

    function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] old,
                                             input logic [DW-1:0] wd,
                                             input logic [3:0] be);
        wmerge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                wmerge[8*i +: 8] = wd[8*i +: 8];
            end
        end
    endfunction

    rsc_state_t st_reg;
    rsc_state_t st_next;
    logic scan_tick;
    logic step_edge;
    logic lim_edge;
    logic cmd_take;
    logic any_cause;
    logic bus_wr;
    logic [IRQ_W-1:0] irq_ev;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] wr_old;

    rsc_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .run(st_reg.scanning),
        .period(st_reg.scan_div),
        .tick(scan_tick)
    );

    // ======================================================
    // request line
    assign any_cause = st_reg.st_limit | st_reg.st_syntax
                     | st_reg.st_settled | st_reg.st_step;
    assign srq = st_reg.req_en & any_cause;
    assign step_edge = st_reg.step_s2 & ~st_reg.step_s3;
    assign lim_edge = st_reg.lim_s2 & ~st_reg.lim_s3;
    // only the addressed listeners act on a code
    assign cmd_take = cmd_valid & listen_addressed;
    assign bus_wr = avs_write & st_reg.ack;

    // ======================================================
    // next state
    always_comb begin
        st_next = st_reg;
        irq_ev = '0;
        rd_word = '0;
        wr_old = '0;
        st_next.talk_valid = 1'b0;
        st_next.poll_valid = 1'b0;
        st_next.step_s1 = external_step_input;
        st_next.step_s2 = st_reg.step_s1;
        st_next.step_s3 = st_reg.step_s2;
        st_next.lim_s1 = limiter_active;
        st_next.lim_s2 = st_reg.lim_s1;
        st_next.lim_s3 = st_reg.lim_s2;

        // poll clears first so that a cause arriving now still sets
        if (poll_req) begin
            st_next.poll_byte = sb_pack(st_reg, srq);
            st_next.poll_valid = 1'b1;
            st_next.st_limit = 1'b0;
            st_next.st_settled = 1'b0;
            st_next.st_step = 1'b0;
            irq_ev[IRQ_POLL] = 1'b1;
        end
        if (talk_req) begin
            st_next.talk_data = st_reg.set_val;
            st_next.talk_valid = 1'b1;
        end

        if (st_reg.scanning && scan_tick) begin
            st_next.set_val = st_reg.set_val + UNIT_STEP;
        end

        // bus write before codes: a code in the same cycle wins
        if (bus_wr) begin
            if (avs_address == REG_CTRL) begin
                wr_old[CTRL_REQ_EN] = st_reg.req_en;
                wr_old = wmerge(wr_old, avs_writedata, avs_byteenable);
                st_next.req_en = wr_old[CTRL_REQ_EN];
            end else if (avs_address == REG_IRQ_STAT) begin
                wr_old[IRQ_W-1:0] = st_reg.irq_stat;
                wr_old = wmerge(wr_old, avs_writedata, avs_byteenable);
                st_next.irq_stat = st_reg.irq_stat & ~wr_old[IRQ_W-1:0];
            end else if (avs_address == REG_IRQ_MASK) begin
                wr_old[IRQ_W-1:0] = st_reg.irq_mask;
                wr_old = wmerge(wr_old, avs_writedata, avs_byteenable);
                st_next.irq_mask = wr_old[IRQ_W-1:0];
            end else if (avs_address == REG_SCAN_DIV) begin
                wr_old[TICK_W-1:0] = st_reg.scan_div;
                wr_old = wmerge(wr_old, avs_writedata, avs_byteenable);
                st_next.scan_div = wr_old[TICK_W-1:0];
            end
        end

        // one code per cycle, applied in arrival order
        if (cmd_take) begin
            // any well-formed code other than NOP counts as the corrected statement
            if (cmd_op != CMD_BAD && cmd_op != CMD_NOP) begin
                st_next.st_syntax = 1'b0;
            end
            case (cmd_op)
                CMD_STANDBY: begin
                    st_next.operate = 1'b0;
                    st_next.st_settled = 1'b0;
                end
                CMD_OPERATE: begin
                    st_next.operate = 1'b1;
                    if (st_reg.buf_valid) begin
                        st_next.set_val = st_reg.buf_val;
                        st_next.buf_valid = 1'b0;
                    end
                    st_next.st_settled = 1'b1;
                end
                CMD_SET: begin
                    st_next.set_val = cmd_data;
                    if (st_reg.operate) begin
                        st_next.st_settled = 1'b1;
                    end
                end
                CMD_BUF: begin
                    st_next.buf_val = cmd_data;
                    st_next.buf_valid = 1'b1;
                end
                CMD_REQ_EN: st_next.req_en = 1'b1;
                CMD_REQ_DIS: st_next.req_en = 1'b0;
                CMD_CONT: st_next.scanning = 1'b1;
                CMD_RANGE: st_next.range = cmd_data[RANGE_W-1:0];
                CMD_CLEAR: begin
                    st_next.req_en = 1'b0;
                    st_next.operate = 1'b0;
                    st_next.scanning = 1'b0;
                    st_next.st_limit = 1'b0;
                    st_next.st_settled = 1'b0;
                    st_next.st_step = 1'b0;
                    st_next.set_val = '0;
                    st_next.buf_val = '0;
                    st_next.buf_valid = 1'b0;
                    st_next.range = '0;
                end
                CMD_BAD: begin
                    // the faulty parameter keeps its old value
                    st_next.st_syntax = 1'b1;
                    irq_ev[IRQ_SYNTAX] = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // events last: a cause in a poll or clear cycle still sets
        // edge only: a persisting overload requests once
        if (lim_edge) begin
            st_next.st_limit = 1'b1;
            irq_ev[IRQ_LIMIT] = 1'b1;
        end
        if (st_reg.scanning && step_edge) begin
            st_next.scanning = 1'b0;
            st_next.st_step = 1'b1;
            irq_ev[IRQ_STEP] = 1'b1;
        end

        // set wins over write-one-to-clear
        st_next.irq_stat = st_next.irq_stat | irq_ev;

        // ==================================================
        // bus answer: one wait cycle, read data from a flop
        if (avs_address == REG_CTRL) begin
            rd_word[CTRL_REQ_EN] = st_reg.req_en;
        end else if (avs_address == REG_STATE) begin
            rd_word[7:0] = sb_pack(st_reg, srq);
            rd_word[ST_SRQ] = srq;
            rd_word[ST_OPERATE] = st_reg.operate;
            rd_word[ST_SCANNING] = st_reg.scanning;
            rd_word[ST_BUF_VALID] = st_reg.buf_valid;
            rd_word[ST_RANGE +: RANGE_W] = st_reg.range;
        end else if (avs_address == REG_SETVAL) begin
            rd_word[VAL_W-1:0] = st_reg.set_val;
        end else if (avs_address == REG_BUFVAL) begin
            rd_word[VAL_W-1:0] = st_reg.buf_val;
        end else if (avs_address == REG_IRQ_STAT) begin
            rd_word[IRQ_W-1:0] = st_reg.irq_stat;
        end else if (avs_address == REG_IRQ_MASK) begin
            rd_word[IRQ_W-1:0] = st_reg.irq_mask;
        end else if (avs_address == REG_SCAN_DIV) begin
            rd_word[TICK_W-1:0] = st_reg.scan_div;
        end
        st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
        if (avs_read && !st_reg.ack) begin
            st_next.rdata = rd_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.scan_div <= SCAN_PERIOD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
    assign avs_readdata = st_reg.rdata;
    assign poll_byte = st_reg.poll_byte;
    assign poll_valid = st_reg.poll_valid;
    assign talk_data = st_reg.talk_data;
    assign talk_valid = st_reg.talk_valid;
    assign level_out = st_reg.set_val;
    assign output_on = st_reg.operate;
    assign range_out = st_reg.range;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

    // ======================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_limit_held: assert property (
        st_reg.st_limit && !poll_req && !(cmd_take && cmd_op == CMD_CLEAR)
        |=> st_reg.st_limit)
        else $error("overload cause lost without a poll");
    a_syntax_held: assert property (
        st_reg.st_syntax && !(cmd_take && cmd_op != CMD_NOP)
        |=> st_reg.st_syntax)
        else $error("syntax cause lost without correction");
    a_rqs_bit: assert property (
        poll_req |=> poll_valid && poll_byte[SB_RQS] == $past(srq)
                     && (poll_byte >= 8'h40) == $past(srq))
        else $error("request bit of polled byte wrong");
    a_limit_set: assert property (
        lim_edge |=> st_reg.st_limit && st_reg.irq_stat[IRQ_LIMIT])
        else $error("limiter edge did not set bit 0");
    a_syntax_set: assert property (
        cmd_take && cmd_op == CMD_BAD
        |=> st_reg.st_syntax && st_reg.irq_stat[IRQ_SYNTAX])
        else $error("bad code did not set bit 1");
    a_step_stop: assert property (
        st_reg.scanning && step_edge
        |=> !st_reg.scanning && st_reg.st_step)
        else $error("step input did not stop the scan");
    a_talk_value: assert property (
        talk_req |=> talk_valid && talk_data == $past(st_reg.set_val))
        else $error("talker value is not the set value");
    a_scan_step: assert property (
        st_reg.scanning && scan_tick && !cmd_take
        |=> level_out == $past(level_out) + UNIT_STEP)
        else $error("scan did not step the units digit");
    a_buf_hold: assert property (
        cmd_take && cmd_op == CMD_BUF && !(st_reg.scanning && scan_tick)
        |=> level_out == $past(level_out) && st_reg.buf_valid)
        else $error("buffered value reached the output");
    a_operate_load: assert property (
        cmd_take && cmd_op == CMD_OPERATE && st_reg.buf_valid
        |=> output_on && level_out == $past(st_reg.buf_val))
        else $error("operate did not apply the buffer");
    a_srq_gate: assert property (
        cmd_take && cmd_op == CMD_REQ_DIS |=> !srq && !st_reg.req_en)
        else $error("request issued while disabled or idle");

    c_poll_rqs: cover property (poll_req ##1 poll_byte[SB_RQS]);
    c_step_stop: cover property (st_reg.scanning && step_edge);
    c_buf_operate: cover property (
        cmd_take && cmd_op == CMD_BUF ##[1:20]
        cmd_take && cmd_op == CMD_OPERATE);
    c_syntax_fix: cover property (st_reg.st_syntax ##1 !st_reg.st_syntax);
endmodule // rsc_ctrl
`default_nettype wire

/* src/rsc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// scan rate divider: one-cycle enable every period cycles
module rsc_tick import rsc_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic run, // count while high, restart when low
    input wire logic [TICK_W-1:0] period, // cycles per tick
    output logic tick // one-cycle pulse
);
    rsc_tick_state_t st_reg;
    rsc_tick_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!run) begin
            st_next.cnt = '0;
        // a period of zero or one still ticks every cycle
        end else if (st_reg.cnt + 1'b1 >= period) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule // rsc_tick
`default_nettype wire
